// [design/event_pkg.sv]
`default_nettype none
package event_pkg;
  // ----------------------------------------------------------------
  // Level numbering
  // ----------------------------------------------------------------
  localparam int NUM_LEVELS = 16;
  localparam logic [3:0] LVL_EMU = 4'h0;
  localparam logic [3:0] LVL_RESET = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXC = 4'h3;
  localparam logic [3:0] LVL_RSVD = 4'h4;
  localparam logic [3:0] LVL_HWERR = 4'h5;
  localparam logic [3:0] LVL_TIMER = 4'h6;
  localparam logic [3:0] LVL_GP_FIRST = 4'h7;
  localparam logic [3:0] LVL_GP_LAST = 4'hf;
  localparam int NUM_GP = 9;
  localparam int VEC_W = 32;
  // Reset values of the event state
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h001f;
  localparam logic [15:0] ACTIVE_RESET = 16'h0000;
  // Levels that can never be masked (emulation..exception)
  localparam logic [15:0] UNMASKABLE = 16'h000f;
  localparam logic [15:0] RSVD_MASK = 16'h0010;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic emulation;
    logic nmi_pin;
    logic watchdog;
    logic align_fault;
    logic undef_instr;
    logic hw_error;
    logic core_timer;
  } core_sources_t;

  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [VEC_W-1:0] vector;
    logic [VEC_W-1:0] return_addr;
  } dispatch_t;

  typedef struct packed {
    logic write;
    logic [15:0] data;
  } reg_write_t;

  // Dispatch engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_ENTER = 3'b100
  } disp_state_t;
endpackage
`default_nettype wire

// [design/level_picker.sv]
`default_nettype none
// ------------------------------------------------------------------
// Highest-priority (lowest index) pick among request bits
// ------------------------------------------------------------------
module level_picker #(
  parameter int N = 16
) (
  // Candidates
  input wire logic [N-1:0] req,
  // Winner
  output logic found,
  output logic [3:0] level
);
  // Scan from lowest priority up so the highest wins
  always_comb begin
    found = 1'b0;
    level = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        level = 4'(i);
      end
    end
  end
endmodule // level_picker
`default_nettype wire

// [design/core_event_stage.sv]
// Behaviour
// - Sixteen levels, zero highest, fixed order
// - Higher priority pending event serviced first
// - Nested routines, higher pre-empts lower
// - Emulation event enters emulation mode
// - Reset event resets the processor
// - Watchdog or NMI pin raise NMI
// - Exceptions synchronous, alignment and undefined
// - Asynchronous interrupts, including software raise
// - Return address register per event level
// - State saved on supervisor stack first
// - Router drives general-purpose inputs directly
// - Nine general-purpose levels seven to fifteen
// - Latch set on capture, cleared on accept
// - Enable bit gates servicing, latch stays
// - Active bit per nested event
`default_nettype none
module core_event_stage #(
  parameter int VEC_W = event_pkg::VEC_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Asynchronous event pins and sources
  input wire logic emu_pin,
  input wire logic nmi_pin,
  input wire logic watchdog_expired,
  input wire logic hw_error_pin,
  // General-purpose inputs from peripheral_irq_router
  input wire logic [event_pkg::NUM_GP-1:0] gp_irq,
  // Sequencer side, same clock
  input wire logic align_fault,
  input wire logic undef_instr,
  input wire logic core_timer_irq,
  input wire logic sw_raise,
  input wire logic [3:0] sw_raise_level,
  input wire logic [VEC_W-1:0] current_pc,
  input wire logic return_from_event,
  input wire logic [3:0] return_level,
  input wire logic gp_global_enable,
  input wire logic supervisor,
  // Supervisor writes to latch and enable bits
  input wire event_pkg::reg_write_t latch_wr,
  input wire event_pkg::reg_write_t enable_wr,
  // Vector table entries, one per level
  input wire logic [event_pkg::NUM_LEVELS*VEC_W-1:0] event_vector_table,
  // Outputs to the sequencer
  output event_pkg::dispatch_t dispatch,
  output logic save_state,
  output logic fault_hold,
  output logic emulation_mode,
  output logic core_reset,
  output logic [VEC_W-1:0] resume_addr,
  // Status, visible to supervisor reads
  output logic [15:0] event_latch_bits,
  output logic [15:0] event_enable_bits,
  output logic [15:0] event_active_bits
);
  localparam int NL = event_pkg::NUM_LEVELS;

  // ----------------------------------------------------------------
  // Input synchronisers for pins from outside the clock domain
  // ----------------------------------------------------------------
  localparam int NSYNC = 4 + event_pkg::NUM_GP;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_prev;
  logic [NSYNC-1:0] sync_rise;

  // Two flops, then a third stage for edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_prev <= '0;
    end else begin
      sync_a <= {gp_irq, hw_error_pin, watchdog_expired, nmi_pin, emu_pin};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign sync_rise = sync_b & ~sync_prev;

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  logic [NL-1:0] capture;
  logic [NL-1:0] accept;
  logic [NL-1:0] retire;
  logic sw_ok;

  // Software raise limited to the general-purpose levels
  assign sw_ok = sw_raise && (sw_raise_level >= event_pkg::LVL_GP_FIRST);

  // Map each hardware source onto its fixed level, software raise onto sw_raise_level
  always_comb begin
    capture = '0;
    capture[event_pkg::LVL_EMU] = sync_rise[0];
    capture[event_pkg::LVL_NMI] = sync_rise[1] | sync_rise[2];
    capture[event_pkg::LVL_EXC] = align_fault | undef_instr;
    capture[event_pkg::LVL_HWERR] = sync_rise[3];
    capture[event_pkg::LVL_TIMER] = core_timer_irq;
    capture[NL-1:event_pkg::LVL_GP_FIRST] = sync_rise[NSYNC-1:4];
    if (sw_ok) begin
      capture[sw_raise_level] = 1'b1;
    end
  end

  // Exception stalls the faulting instruction until taken
  assign fault_hold = event_latch_bits[event_pkg::LVL_EXC];

  // ----------------------------------------------------------------
  // Latch bits: set wins over clear and over writes
  // ----------------------------------------------------------------
  // Unmaskable levels have no enable to clear, so stay writable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_latch_bits <= event_pkg::LATCH_RESET;
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (capture[i]) begin
          event_latch_bits[i] <= 1'b1;
        end else if (accept[i]) begin
          event_latch_bits[i] <= 1'b0;
        end else if (latch_wr.write && supervisor &&
                     (!event_enable_bits[i] ||
                      event_pkg::UNMASKABLE[i])) begin
          event_latch_bits[i] <= latch_wr.data[i];
        end
      end
      event_latch_bits[event_pkg::LVL_RSVD] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Enable bits: top levels always enabled, reserved set at reset and cleared on every write
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_enable_bits <= event_pkg::ENABLE_RESET;
    end else if (enable_wr.write && supervisor) begin
      event_enable_bits <= (enable_wr.data | event_pkg::UNMASKABLE)
                           & ~event_pkg::RSVD_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Candidate selection
  // ----------------------------------------------------------------
  logic [NL-1:0] eligible;
  logic [NL-1:0] gp_gate;
  logic cand_found;
  logic [3:0] cand_level;
  logic act_found;
  logic [3:0] act_level;

  // Global enable gates only general-purpose levels
  always_comb begin
    gp_gate = '1;
    if (!gp_global_enable) begin
      gp_gate[NL-1:event_pkg::LVL_GP_FIRST] = '0;
    end
  end

  assign eligible = event_latch_bits & event_enable_bits & gp_gate;

  level_picker #(.N(NL)) pick_cand (
    .req(eligible),
    .found(cand_found),
    .level(cand_level)
  );

  level_picker #(.N(NL)) pick_active (
    .req(event_active_bits),
    .found(act_found),
    .level(act_level)
  );

  // Pre-empt only when strictly above every active level
  logic preempt;
  assign preempt = cand_found &&
                   (!act_found || cand_level < act_level);

  // ----------------------------------------------------------------
  // Dispatch engine: save state, then enter routine
  // ----------------------------------------------------------------
  event_pkg::disp_state_t state;
  event_pkg::disp_state_t next_state;
  logic [3:0] taken_level;

  always_comb begin
    next_state = state;
    unique case (state)
      event_pkg::ST_IDLE: begin
        if (preempt) begin
          next_state = event_pkg::ST_SAVE;
        end
      end
      event_pkg::ST_SAVE: begin
        next_state = event_pkg::ST_ENTER;
      end
      event_pkg::ST_ENTER: begin
        next_state = event_pkg::ST_IDLE;
      end
      default: begin
        next_state = event_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= event_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Winning level frozen while state is saved
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_level <= 4'h0;
    end else if (state == event_pkg::ST_IDLE && preempt) begin
      taken_level <= cand_level;
    end
  end

  assign save_state = (state == event_pkg::ST_SAVE);

  // Accept clears the latch when the routine is entered
  always_comb begin
    accept = '0;
    if (state == event_pkg::ST_ENTER) begin
      accept[taken_level] = 1'b1;
    end
  end

  // Return retires the named active level
  always_comb begin
    retire = '0;
    if (return_from_event) begin
      retire[return_level] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Active bits track nesting
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_active_bits <= event_pkg::ACTIVE_RESET;
    end else begin
      event_active_bits <= (event_active_bits & ~retire) | accept;
    end
  end

  // ----------------------------------------------------------------
  // Return address registers, one per level
  // ----------------------------------------------------------------
  logic [VEC_W-1:0] ret_addr [NL];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NL; i++) begin
        ret_addr[i] <= '0;
      end
    end else if (state == event_pkg::ST_SAVE) begin
      ret_addr[taken_level] <= current_pc;
    end
  end

  // Address handed back on return-from-event
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_addr <= '0;
    end else if (return_from_event) begin
      resume_addr <= ret_addr[return_level];
    end
  end

  // ----------------------------------------------------------------
  // Dispatch outputs to the sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispatch <= '0;
    end else begin
      dispatch.valid <= (state == event_pkg::ST_ENTER);
      dispatch.level <= taken_level;
      dispatch.vector <= event_vector_table[taken_level*VEC_W +: VEC_W];
      dispatch.return_addr <= ret_addr[taken_level];
    end
  end

  // Mode outputs for emulation and reset events
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      emulation_mode <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      emulation_mode <= event_active_bits[event_pkg::LVL_EMU] |
                        accept[event_pkg::LVL_EMU];
      core_reset <= accept[event_pkg::LVL_RESET];
    end
  end

  // Reset event is raised by software through the latch write path
  // Levels 14 and 15 are left to software by convention only
  // General levels 7..15 come from gp_irq through the input synchronisers
endmodule // core_event_stage
`default_nettype wire

// [verif/event_checker_assertions.sv]
`default_nettype none
module event_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Observed outputs
  input wire event_pkg::dispatch_t dispatch,
  input wire logic save_state,
  input wire logic fault_hold,
  input wire logic emulation_mode,
  input wire logic core_reset,
  input wire logic [15:0] event_latch_bits,
  input wire logic [15:0] event_enable_bits,
  input wire logic [15:0] event_active_bits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Dispatch sequence
  // ----
  chk_save_then_entry: assert property (
    save_state |-> ##2 dispatch.valid) else $error("no entry after save");
  chk_dispatch_spacing: assert property (
    dispatch.valid |=> !dispatch.valid [*2]) else $error("dispatch too close");
  chk_active_on_entry: assert property (
    dispatch.valid |-> event_active_bits[dispatch.level])
    else $error("active bit missing");
  chk_latch_cleared: assert property (
    dispatch.valid |-> !event_latch_bits[dispatch.level])
    else $error("latch not cleared");
  chk_strict_preempt: assert property (
    dispatch.valid |-> ($past(event_active_bits, 2)
      & ~(16'hfffe << dispatch.level)) == 16'h0000)
    else $error("dispatch not above active");
  chk_emu_mode_set: assert property (
    dispatch.valid && dispatch.level == 4'h0 |-> ##[0:2] emulation_mode)
    else $error("emulation mode missing");
  // ----
  // Static relations
  // ----
  chk_unmaskable_on: assert property (
    event_enable_bits[3:0] == 4'hf) else $error("unmaskable bit cleared");
  chk_fault_mirror: assert property (
    fault_hold == event_latch_bits[3]) else $error("fault hold mismatch");
  chk_reset_pulse: assert property (
    core_reset |=> !core_reset) else $error("reset pulse too long");
  cov_dispatch: cover property (dispatch.valid);
  cov_nested: cover property (
    dispatch.valid && $countones(event_active_bits) > 1);
  cov_emu: cover property (emulation_mode);
endmodule // event_checker
bind core_event_stage event_checker u_event_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .dispatch(dispatch),
  .save_state(save_state), .fault_hold(fault_hold),
  .emulation_mode(emulation_mode), .core_reset(core_reset),
  .event_latch_bits(event_latch_bits),
  .event_enable_bits(event_enable_bits),
  .event_active_bits(event_active_bits));
`default_nettype wire

// [verif/irq_router_model.sv]
`default_nettype none
module irq_router_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Peripheral requests
  input wire logic [6:0] periph_req,
  // Toward the core event stage
  output logic [event_pkg::NUM_GP-1:0] gp_irq,
  output logic [31:0] current_pc
);
  // Peripherals straight onto 7..13, top two left to software
  assign gp_irq = {2'b00, periph_req};
  // Sequencer program counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_pc <= 32'h0;
    end else begin
      current_pc <= current_pc + 32'h4;
    end
  end
endmodule // irq_router_model
`default_nettype wire

// [verif/testbench.sv]
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_total++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Wiring
  // ----
  logic ref_clk, rst_n, emu_pin, nmi_pin, watchdog_expired, hw_error_pin;
  logic align_fault, undef_instr, core_timer_irq, sw_raise;
  logic return_from_event, gp_global_enable, supervisor;
  logic [3:0] sw_raise_level, return_level;
  logic [6:0] periph_req;
  logic [8:0] gp_irq;
  logic [31:0] current_pc, resume_addr;
  logic [511:0] event_vector_table;
  event_pkg::reg_write_t latch_wr, enable_wr;
  event_pkg::dispatch_t dispatch;
  logic save_state, fault_hold, emulation_mode, core_reset;
  logic [15:0] event_latch_bits, event_enable_bits, event_active_bits;
  logic [31:0] ra [16];
  int err_total = 0;
  int samples_checked = 0;
  core_event_stage u_core_event_stage (.ref_clk(ref_clk), .rst_n(rst_n),
    .emu_pin(emu_pin), .nmi_pin(nmi_pin),
    .watchdog_expired(watchdog_expired), .hw_error_pin(hw_error_pin),
    .gp_irq(gp_irq), .align_fault(align_fault), .undef_instr(undef_instr),
    .core_timer_irq(core_timer_irq), .sw_raise(sw_raise),
    .sw_raise_level(sw_raise_level), .current_pc(current_pc),
    .return_from_event(return_from_event), .return_level(return_level),
    .gp_global_enable(gp_global_enable), .supervisor(supervisor),
    .latch_wr(latch_wr), .enable_wr(enable_wr),
    .event_vector_table(event_vector_table), .dispatch(dispatch),
    .save_state(save_state), .fault_hold(fault_hold),
    .emulation_mode(emulation_mode), .core_reset(core_reset),
    .resume_addr(resume_addr), .event_latch_bits(event_latch_bits),
    .event_enable_bits(event_enable_bits),
    .event_active_bits(event_active_bits));
  irq_router_model u_irq_router_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .periph_req(periph_req), .gp_irq(gp_irq), .current_pc(current_pc));
  // Clock
  always #5 ref_clk = ~ref_clk;
  // ----
  // Helpers
  // ----
  task automatic wait_disp(input logic [3:0] lvl);
    int n;
    n = 0;
    while (dispatch.valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(dispatch.valid, 1'b1)
    `CHK(dispatch.level, lvl)
    `CHK(core_reset, lvl == 4'h1)
    `CHK(dispatch.vector, 32'h100 + lvl * 4)
    `CHK(dispatch.return_addr, current_pc - 32'h8)
    `CHK(event_active_bits[lvl], 1'b1)
    ra[lvl] = current_pc - 32'h8;
    @(negedge ref_clk);
  endtask
  task automatic ret(input logic [3:0] lvl);
    return_level = lvl;
    return_from_event = 1'b1;
    @(negedge ref_clk);
    return_from_event = 1'b0;
    `CHK(resume_addr, ra[lvl])
    `CHK(event_active_bits[lvl], 1'b0)
    @(negedge ref_clk);
  endtask
  task automatic put(input logic lat, input logic [15:0] d);
    if (lat) latch_wr = {1'b1, d};
    else enable_wr = {1'b1, d};
    @(negedge ref_clk);
    latch_wr = '0;
    enable_wr = '0;
    @(negedge ref_clk);
  endtask
  task stop_test;
    $display("Counts: %0d checks, %0d mismatches", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_basic;
    supervisor = 1'b1;
    gp_global_enable = 1'b1;
    put(1'b0, 16'hffff);
    periph_req = 7'h01;
    wait_disp(4'h7);
    periph_req = 7'h00;
    ret(4'h7);
    $display("basic dispatch test done");
  endtask
  task t_priority;
    periph_req = 7'h0a;
    wait_disp(4'h8);
    periph_req = 7'h00;
    repeat (6) @(negedge ref_clk);
    `CHK(event_latch_bits[10], 1'b1)
    ret(4'h8);
    wait_disp(4'ha);
    ret(4'ha);
    $display("priority test done");
  endtask
  task t_nest;
    periph_req = 7'h20;
    wait_disp(4'hc);
    hw_error_pin = 1'b1;
    wait_disp(4'h5);
    `CHK(event_active_bits & 16'h1020, 16'h1020)
    hw_error_pin = 1'b0;
    periph_req = 7'h00;
    ret(4'h5);
    ret(4'hc);
    $display("nesting test done");
  endtask
  task t_core;
    align_fault = 1'b1;
    @(negedge ref_clk);
    align_fault = 1'b0;
    wait_disp(4'h3);
    watchdog_expired = 1'b1;
    wait_disp(4'h2);
    ret(4'h2);
    nmi_pin = 1'b1;
    wait_disp(4'h2);
    ret(4'h2);
    emu_pin = 1'b1;
    wait_disp(4'h0);
    `CHK(emulation_mode, 1'b1)
    ret(4'h0);
    ret(4'h3);
    {emu_pin, nmi_pin, watchdog_expired} = 3'b000;
    $display("core event test done");
  endtask
  task t_mask;
    put(1'b0, 16'hfdff);
    periph_req = 7'h04;
    repeat (10) @(negedge ref_clk);
    periph_req = 7'h00;
    `CHK(event_latch_bits[9], 1'b1)
    `CHK(event_active_bits[9], 1'b0)
    put(1'b1, 16'h0000);
    `CHK(event_latch_bits[9], 1'b0)
    supervisor = 1'b0;
    put(1'b0, 16'h0000);
    `CHK(event_enable_bits, 16'hfdef)
    supervisor = 1'b1;
    put(1'b0, 16'hffff);
    $display("mask test done");
  endtask
  task t_sw;
    sw_raise_level = 4'h6;
    sw_raise = 1'b1;
    @(negedge ref_clk);
    sw_raise_level = 4'he;
    @(negedge ref_clk);
    sw_raise = 1'b0;
    wait_disp(4'he);
    `CHK(event_latch_bits, 16'h0000)
    ret(4'he);
    $display("software raise test done");
  endtask
  task t_misc;
    core_timer_irq = 1'b1;
    @(negedge ref_clk);
    core_timer_irq = 1'b0;
    wait_disp(4'h6);
    ret(4'h6);
    undef_instr = 1'b1;
    @(negedge ref_clk);
    undef_instr = 1'b0;
    `CHK(fault_hold, 1'b1)
    wait_disp(4'h3);
    ret(4'h3);
    gp_global_enable = 1'b0;
    periph_req = 7'h01;
    repeat (8) @(negedge ref_clk);
    `CHK(event_latch_bits[7], 1'b1)
    `CHK(event_active_bits[7], 1'b0)
    gp_global_enable = 1'b1;
    wait_disp(4'h7);
    periph_req = 7'h00;
    ret(4'h7);
    put(1'b1, 16'h0002);
    wait_disp(4'h1);
    ret(4'h1);
    $display("timer, fault, gate and reset test done");
  endtask
  // Watchdog
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
  // Main sequence
  initial begin
    {ref_clk, rst_n, emu_pin, nmi_pin, watchdog_expired} = '0;
    {hw_error_pin, align_fault, undef_instr, core_timer_irq} = '0;
    {sw_raise, return_from_event, gp_global_enable, supervisor} = '0;
    {sw_raise_level, return_level, periph_req} = '0;
    {latch_wr, enable_wr} = '0;
    for (int i = 0; i < 16; i++) event_vector_table[i*32+:32] = 32'h100 + i * 4;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK(event_enable_bits, 16'h001f)
    `CHK(event_active_bits, 16'h0000)
    t_basic;
    t_priority;
    t_nest;
    t_core;
    t_mask;
    t_sw;
    t_misc;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
